/* File: src/bci_cmd.sv */
// Boot command interpreter: configuration request and inquiry commands
// Summary of operation
// - While idle, drop every byte until a start-of-header byte arrives.
// - Missing terminator in final position answers with packet error.
// - Checksum mismatch answers with checksum error.
// - Length outside the general packet format answers with packet error.
// - Length not fixed command length answers with packet error.
// - Any error skips execution, changes nothing, returns to waiting.
// - Report only top error: terminator, checksum, format, length, acceptance.
// - Framing, lifecycle and auth errors fill both fields with unused code.
// - Configuration request refused when lifecycle state forbids it.
// - Configuration request gives secure error at auth level one or zero.
// - Config success: 81h, 00h/05h, 4Dh, four bytes lowest address first.
// - Config failure: length 00h/0Ah, code CDh, status, details, address.
// - Inquiry refused while encrypted write awaits a device reset.
// - Inquiry success: 81h, 00h/0Ah, 00h, 00h, unused fields, sum FEh.
// - Inquiry failure uses response code 80h with ten-byte payload.
`include "bci_regs.svh"

module bci_cmd (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire bci_pkg::bci_byte_type rx_in,
    output logic                      rx_ready,
    output bci_pkg::bci_byte_type     tx_out,
    input  wire logic                 tx_ready,
    input  wire bci_pkg::bci_acc_type acc,
    input  wire logic [31:0]          arc_config
);

    bci_pkg::bci_state_type state_r, state_nxt;
    logic [15:0]            len_r, len_nxt;
    logic [15:0]            cnt_r, cnt_nxt;
    logic [7:0]             sum_r, sum_nxt;
    logic [7:0]             cmd_r, cmd_nxt;
    logic [7:0]             buf_r [0:`BCI_BUF_LAST];
    logic [7:0]             buf_nxt [0:`BCI_BUF_LAST];
    logic [3:0]             flen_r, flen_nxt;
    logic [3:0]             idx_r, idx_nxt;
    bci_pkg::bci_byte_type  tx_r, tx_nxt;
    logic                   rx_ready_r, rx_ready_nxt;

    logic       take;
    logic [7:0] byte_in;
    logic [7:0] pay [0:`BCI_PAY_LAST];
    logic [3:0] plen;
    logic [7:0] acc_sum;
    logic [7:0] csum;
    logic [7:0] status_code;
    logic [7:0] response_code;
    logic       ok;
    logic       is_arc;
    logic       is_inq;
    logic       fmt_bad;

    assign take     = rx_in.valid && rx_ready_r;
    assign byte_in  = rx_in.data;
    assign rx_ready = rx_ready_r;
    assign tx_out   = tx_r;

    always_comb begin
        state_nxt = state_r;
        len_nxt   = len_r;
        cnt_nxt   = cnt_r;
        sum_nxt   = sum_r;
        cmd_nxt   = cmd_r;
        buf_nxt   = buf_r;
        flen_nxt  = flen_r;
        idx_nxt   = idx_r;
        tx_nxt    = tx_r;
        for (int i = 0; i <= `BCI_PAY_LAST; i++) begin
            pay[i] = `BCI_ZERO_BYTE;
        end
        plen    = `BCI_ZERO_IDX;
        acc_sum = `BCI_ZERO_BYTE;
        csum    = `BCI_ZERO_BYTE;
        status_code   = `BCI_STAT_OK;
        response_code = `BCI_ZERO_BYTE;
        ok      = 1'b0;
        is_arc  = (cmd_r == `BCI_CMD_ARC);
        is_inq  = (cmd_r == `BCI_CMD_INQ);
        // Lower bound: a packet must hold its command code
        fmt_bad = (len_r == `BCI_ZERO_LEN) || (len_r > `BCI_FMT_MAX_LEN);
        case (state_r)
            bci_pkg::ST_WAIT: begin
                if (take && byte_in == `BCI_SOH) begin
                    len_nxt   = `BCI_ZERO_LEN;
                    cnt_nxt   = `BCI_ZERO_LEN;
                    sum_nxt   = `BCI_ZERO_BYTE;
                    // Empty packet still gets an answer, as an inquiry
                    cmd_nxt   = `BCI_CMD_INQ;
                    state_nxt = bci_pkg::ST_LEN_HI;
                end
            end
            bci_pkg::ST_LEN_HI: begin
                if (take) begin
                    len_nxt   = {byte_in, `BCI_ZERO_BYTE};
                    sum_nxt   = sum_r + byte_in;
                    state_nxt = bci_pkg::ST_LEN_LO;
                end
            end
            bci_pkg::ST_LEN_LO: begin
                if (take) begin
                    len_nxt = {len_r[15:8], byte_in};
                    sum_nxt = sum_r + byte_in;
                    if ({len_r[15:8], byte_in} == `BCI_ZERO_LEN) begin
                        state_nxt = bci_pkg::ST_SUM;
                    end else begin
                        state_nxt = bci_pkg::ST_PAY;
                    end
                end
            end
            bci_pkg::ST_PAY: begin
                if (take) begin
                    if (cnt_r == `BCI_ZERO_LEN) begin
                        cmd_nxt = byte_in;
                    end
                    sum_nxt = sum_r + byte_in;
                    cnt_nxt = cnt_r + `BCI_ONE_LEN;
                    if (cnt_nxt == len_r) begin
                        state_nxt = bci_pkg::ST_SUM;
                    end
                end
            end
            bci_pkg::ST_SUM: begin
                if (take) begin
                    sum_nxt   = sum_r + byte_in;
                    state_nxt = bci_pkg::ST_ETX;
                end
            end
            bci_pkg::ST_ETX: begin
                if (take) begin
                    // Priority order of the checks below matters
                    if (byte_in != `BCI_ETX) begin
                        status_code = `BCI_STAT_PKT_ERR;
                    end else if (sum_r != `BCI_ZERO_BYTE) begin
                        status_code = `BCI_STAT_SUM_ERR;
                    end else if (fmt_bad) begin
                        status_code = `BCI_STAT_PKT_ERR;
                    end else if (len_r != `BCI_CMD_LEN) begin
                        status_code = `BCI_STAT_PKT_ERR;
                    end else if (is_arc && !acc.lifecycle_ok) begin
                        status_code = `BCI_STAT_ACC_ERR;
                    end else if (is_arc && (acc.auth_level_one ||
                                            acc.auth_level_zero)) begin
                        status_code = `BCI_STAT_SEC_ERR;
                    end else if (is_inq && acc.enc_write_pending) begin
                        status_code = `BCI_STAT_ACC_ERR;
                    end else begin
                        ok = 1'b1;
                    end
                    if (ok && is_arc) begin
                        response_code = `BCI_RESP_ARC_OK;
                        pay[0] = response_code;
                        pay[1] = arc_config[7:0];
                        pay[2] = arc_config[15:8];
                        pay[3] = arc_config[23:16];
                        pay[4] = arc_config[31:24];
                        plen   = `BCI_PLEN_ARC;
                    end else begin
                        if (is_arc) begin
                            response_code = ok ? `BCI_RESP_ARC_OK
                                : `BCI_RESP_ARC_ERR;
                        end else begin
                            response_code = ok ? `BCI_RESP_INQ_OK
                                : `BCI_RESP_INQ_ERR;
                        end
                        pay[0] = response_code;
                        pay[1] = status_code;
                        for (int i = 2; i <= `BCI_PAY_LAST; i++) begin
                            pay[i] = `BCI_UNUSED_BYTE;
                        end
                        plen = `BCI_PLEN_STATUS;
                    end
                    for (int i = 0; i <= `BCI_PAY_LAST; i++) begin
                        acc_sum = acc_sum + pay[i];
                    end
                    csum = `BCI_ZERO_BYTE - (acc_sum + {4'h0, plen}
                                             + `BCI_LEN_HI_RSP);
                    buf_nxt[0]               = `BCI_DATA_START;
                    buf_nxt[1]               = `BCI_LEN_HI_RSP;
                    buf_nxt[`BCI_POS_LEN_LO] = {4'h0, plen};
                    for (int i = 0; i <= `BCI_PAY_LAST; i++) begin
                        if (4'(i) < plen) begin
                            buf_nxt[4'(i) + `BCI_PAY_BASE] = pay[i];
                        end
                    end
                    buf_nxt[plen + `BCI_PAY_BASE]               = csum;
                    buf_nxt[plen + `BCI_PAY_BASE + `BCI_ONE_IDX] = `BCI_ETX;
                    flen_nxt = plen + `BCI_FRAME_EXTRA;
                    idx_nxt  = `BCI_ZERO_IDX;
                    // Unknown codes are dropped silently; nothing is executed
                    if (is_arc || is_inq) begin
                        state_nxt = bci_pkg::ST_SEND;
                    end else begin
                        state_nxt = bci_pkg::ST_WAIT;
                    end
                end
            end
            bci_pkg::ST_SEND: begin
                if (!tx_r.valid || tx_ready) begin
                    if (idx_r == flen_r) begin
                        tx_nxt.valid = 1'b0;
                        state_nxt    = bci_pkg::ST_WAIT;
                    end else begin
                        tx_nxt.valid = 1'b1;
                        tx_nxt.data  = buf_r[idx_r];
                        idx_nxt      = idx_r + `BCI_ONE_IDX;
                    end
                end
            end
            default: begin
                state_nxt = bci_pkg::ST_WAIT;
            end
        endcase
        // Input stalls while a reply drains, so no command overlaps it
        rx_ready_nxt = (state_nxt != bci_pkg::ST_SEND);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r    <= bci_pkg::ST_WAIT;
            len_r      <= `BCI_ZERO_LEN;
            cnt_r      <= `BCI_ZERO_LEN;
            sum_r      <= `BCI_ZERO_BYTE;
            cmd_r      <= `BCI_CMD_INQ;
            flen_r     <= `BCI_ZERO_IDX;
            idx_r      <= `BCI_ZERO_IDX;
            tx_r       <= '0;
            rx_ready_r <= 1'b1;
            for (int i = 0; i <= `BCI_BUF_LAST; i++) begin
                buf_r[i] <= `BCI_ZERO_BYTE;
            end
        end else begin
            state_r    <= state_nxt;
            len_r      <= len_nxt;
            cnt_r      <= cnt_nxt;
            sum_r      <= sum_nxt;
            cmd_r      <= cmd_nxt;
            flen_r     <= flen_nxt;
            idx_r      <= idx_nxt;
            tx_r       <= tx_nxt;
            rx_ready_r <= rx_ready_nxt;
            buf_r      <= buf_nxt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_wait_soh;
        state_r == bci_pkg::ST_WAIT && take && byte_in != `BCI_SOH
            |=> state_r == bci_pkg::ST_WAIT;
    endproperty
    a_wait_soh: assert property (p_wait_soh)
        else $error("non-header byte left the idle state");

    property p_no_etx;
        state_r == bci_pkg::ST_ETX && take && byte_in != `BCI_ETX
            && (is_arc || is_inq)
            |=> state_r == bci_pkg::ST_SEND
                && buf_r[`BCI_POS_STAT] == `BCI_STAT_PKT_ERR;
    endproperty
    a_no_etx: assert property (p_no_etx)
        else $error("missing terminator not reported as packet error");

    property p_bad_sum;
        state_r == bci_pkg::ST_ETX && take && byte_in == `BCI_ETX
            && sum_r != `BCI_ZERO_BYTE && (is_arc || is_inq)
            |=> buf_r[`BCI_POS_STAT] == `BCI_STAT_SUM_ERR;
    endproperty
    a_bad_sum: assert property (p_bad_sum)
        else $error("checksum error not reported");

    property p_fmt_len;
        state_r == bci_pkg::ST_ETX && take && byte_in == `BCI_ETX
            && sum_r == `BCI_ZERO_BYTE && (is_arc || is_inq)
            && (len_r == `BCI_ZERO_LEN || len_r > `BCI_FMT_MAX_LEN)
            |=> buf_r[`BCI_POS_STAT] == `BCI_STAT_PKT_ERR;
    endproperty
    a_fmt_len: assert property (p_fmt_len)
        else $error("bad packet length not reported as packet error");

    property p_cmd_len;
        state_r == bci_pkg::ST_ETX && take && byte_in == `BCI_ETX
            && sum_r == `BCI_ZERO_BYTE && len_r == `BCI_LEN_TWO && is_arc
            |=> buf_r[`BCI_POS_RESP] == `BCI_RESP_ARC_ERR
                && buf_r[`BCI_POS_STAT] == `BCI_STAT_PKT_ERR;
    endproperty
    a_cmd_len: assert property (p_cmd_len)
        else $error("wrong command length not reported");

    property p_first_byte;
        state_r == bci_pkg::ST_ETX && take && (is_arc || is_inq)
            |=> !rx_ready_r ##1 tx_r.valid && tx_r.data == `BCI_DATA_START;
    endproperty
    a_first_byte: assert property (p_first_byte)
        else $error("reply did not open with data start byte");

    property p_unused;
        state_r == bci_pkg::ST_SEND && flen_r == `BCI_FLEN_STATUS
            |-> buf_r[`BCI_POS_DETAILS] == `BCI_UNUSED_BYTE;
    endproperty
    a_unused: assert property (p_unused)
        else $error("status details not filled with unused code");

    property p_arc_len;
        state_r == bci_pkg::ST_SEND
            && buf_r[`BCI_POS_RESP] == `BCI_RESP_ARC_OK
            |-> buf_r[`BCI_POS_LEN_LO] == {4'h0, `BCI_PLEN_ARC};
    endproperty
    a_arc_len: assert property (p_arc_len)
        else $error("configuration reply length wrong");

    property p_inq_sum;
        state_r == bci_pkg::ST_SEND
            && buf_r[`BCI_POS_RESP] == `BCI_RESP_INQ_OK
            && buf_r[`BCI_POS_STAT] == `BCI_STAT_OK
            && buf_r[`BCI_POS_LEN_LO] == {4'h0, `BCI_PLEN_STATUS}
            |-> buf_r[`BCI_POS_SUM_STAT] == `BCI_INQ_OK_SUM;
    endproperty
    a_inq_sum: assert property (p_inq_sum)
        else $error("inquiry reply checksum wrong");

endmodule

/* File: src/bci_pkg.sv */
// Types shared by the boot command interpreter
package bci_pkg;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } bci_byte_type;

    typedef struct packed {
        logic lifecycle_ok;
        logic auth_level_one;
        logic auth_level_zero;
        logic enc_write_pending;
    } bci_acc_type;

    typedef enum logic [6:0] {
        ST_WAIT   = 7'b0000001,
        ST_LEN_HI = 7'b0000010,
        ST_LEN_LO = 7'b0000100,
        ST_PAY    = 7'b0001000,
        ST_SUM    = 7'b0010000,
        ST_ETX    = 7'b0100000,
        ST_SEND   = 7'b1000000
    } bci_state_type;

endpackage

/* File: src/bci_regs.svh */
// Byte codes, field positions and limits of the boot command interpreter
`ifndef BCI_REGS_SVH
`define BCI_REGS_SVH

`define BCI_SOH          8'h01
`define BCI_ETX          8'h03
`define BCI_DATA_START   8'h81
`define BCI_LEN_HI_RSP   8'h00
`define BCI_CMD_INQ      8'h00
`define BCI_CMD_ARC      8'h4D
`define BCI_RESP_INQ_OK  8'h00
`define BCI_RESP_INQ_ERR 8'h80
`define BCI_RESP_ARC_OK  8'h4D
`define BCI_RESP_ARC_ERR 8'hCD
`define BCI_STAT_OK      8'h00
`define BCI_STAT_PKT_ERR 8'hC1
`define BCI_STAT_SUM_ERR 8'hC2
`define BCI_STAT_ACC_ERR 8'hC3
`define BCI_STAT_SEC_ERR 8'hC4
`define BCI_UNUSED_BYTE  8'hFF
`define BCI_INQ_OK_SUM   8'hFE
`define BCI_CMD_LEN      16'h0001
`define BCI_LEN_TWO      16'h0002
`define BCI_FLEN_STATUS  4'hF
`define BCI_FMT_MAX_LEN  16'h0400
`define BCI_PLEN_ARC     4'h5
`define BCI_PLEN_STATUS  4'hA
`define BCI_FRAME_EXTRA  4'h5
`define BCI_PAY_BASE     4'h3
`define BCI_POS_LEN_LO   4'h2
`define BCI_POS_RESP     4'h3
`define BCI_POS_STAT     4'h4
`define BCI_POS_DETAILS  4'h5
`define BCI_POS_SUM_STAT 4'hD
`define BCI_BUF_LAST     14
`define BCI_PAY_LAST     9
`define BCI_ZERO_BYTE    8'h00
`define BCI_ZERO_LEN     16'h0000
`define BCI_ZERO_IDX     4'h0
`define BCI_ONE_IDX      4'h1
`define BCI_ONE_LEN      16'h0001

`endif

/* File: tb/bci_host_model.sv */
// Host tool model: sends command frames and collects reply bytes
module bci_host_model (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    output bci_pkg::bci_byte_type      rx_in,
    input  wire logic                  rx_ready,
    input  wire bci_pkg::bci_byte_type tx_out,
    output logic                       tx_ready,
    input  wire logic                  slow
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got_q[$];
    integer     seed;

    initial begin
        seed = 32'hAEBE;
        rx_in = '{1'b0, 8'hFF};
        tx_ready = 1'b0;
    end

    // Sink may stall at random to exercise the hold of each reply byte
    always @(posedge ref_clk) begin
        if (tx_out.valid && tx_ready && rstn)
            got_q.push_back(tx_out.data);
        #1;
        tx_ready = !slow || ($random(seed) & 1);
    end

    // Called just after an edge; bytes go back to back, held while stalled
    task automatic send_frame(input logic [7:0] f[$]);
        foreach (f[i]) begin
            rx_in = '{1'b1, f[i]};
            while (rx_ready !== 1'b1) begin
                @(posedge ref_clk);
                #1;
            end
            @(posedge ref_clk);
            #1;
        end
        // Released line shows the inverse so a stale byte cannot pass
        rx_in = '{1'b0, ~f[f.size()-1]};
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the boot command interpreter
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  ref_clk;
    logic                  rstn;
    bci_pkg::bci_byte_type rx_in;
    logic                  rx_ready;
    bci_pkg::bci_byte_type tx_out;
    logic                  tx_ready;
    bci_pkg::bci_acc_type  acc;
    logic [31:0]           arc_config;
    logic                  slow;
    integer                seed;
    integer                failures;
    integer                comparisons;
    integer                cycles;
    logic [7:0]            cmd_q[$];
    logic [7:0]            exp_q[$];
    // Row: length, code, checksum skew, terminator, response, status
    logic [55:0]           err_tab[6] = '{56'h0001_4D_01_04_CD_C1,
                                          56'h0002_4D_01_03_CD_C2,
                                          56'h0002_4D_00_03_CD_C1,
                                          56'h0000_00_00_03_80_C1,
                                          56'h0001_00_05_03_80_C2,
                                          56'h0401_4D_00_03_CD_C1};
    logic [3:0]            acc_tab[4] = '{4'h0, 4'h6, 4'hC, 4'hB};
    logic [7:0]            status_tab[4] = '{8'hC3, 8'hC3, 8'hC4, 8'hC4};

    bci_cmd dut_u (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .rx_in      (rx_in),
        .rx_ready   (rx_ready),
        .tx_out     (tx_out),
        .tx_ready   (tx_ready),
        .acc        (acc),
        .arc_config (arc_config)
    );

    bci_host_model host_u (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .rx_in    (rx_in),
        .rx_ready (rx_ready),
        .tx_out   (tx_out),
        .tx_ready (tx_ready),
        .slow     (slow)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want,
                         input string what);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, seen, want);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Ceiling well above the nearly two thousand cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            tally_and_finish();
        end
    end

    function automatic void make_cmd(logic [15:0] len, logic [7:0] code,
                                     logic [7:0] skew, logic [7:0] term);
        logic [7:0] sum;
        sum = 8'h00 - len[15:8] - len[7:0] - code - skew;
        cmd_q = {8'h01, len[15:8], len[7:0]};
        for (int i = 0; i < len; i++)
            cmd_q.push_back(i == 0 ? code : 8'h00);
        cmd_q.push_back(sum);
        cmd_q.push_back(term);
    endfunction

    function automatic void make_status(logic [7:0] resp, logic [7:0] stat);
        exp_q = {8'h81, 8'h00, 8'h0A, resp, stat};
        repeat (8) exp_q.push_back(8'hFF);
        exp_q.push_back(8'h00 - 8'h0A - resp - stat - 8'hF8);
        exp_q.push_back(8'h03);
    endfunction

    function automatic void make_arc(logic [31:0] d);
        exp_q = {8'h81, 8'h00, 8'h05, 8'h4D,
                 d[7:0], d[15:8], d[23:16], d[31:24]};
        exp_q.push_back(8'h00 - 8'h05 - 8'h4D - d[7:0] - d[15:8]
                        - d[23:16] - d[31:24]);
        exp_q.push_back(8'h03);
    endfunction

    // Sends cmd_q and compares the whole reply, then the return to idle
    task automatic run(input string name);
        int n;
        host_u.got_q.delete();
        host_u.send_frame(cmd_q);
        n = 0;
        while (host_u.got_q.size() < exp_q.size() && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        repeat (20) @(posedge ref_clk);
        #1;
        check(8'(host_u.got_q.size()), 8'(exp_q.size()), "reply size");
        foreach (exp_q[i])
            check(host_u.got_q[i], exp_q[i], "reply byte");
        check({7'h00, rx_ready}, 8'h01, "ready after reply");
        $display("test %s done", name);
    endtask

    initial begin
        seed = 32'hAEBE;
        failures = 0;
        comparisons = 0;
        cycles = 0;
        rstn = 1'b0;
        slow = 1'b0;
        acc = '{1'b1, 1'b0, 1'b0, 1'b0};
        arc_config = 32'h0;
        repeat (6) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        @(posedge ref_clk);
        #1;
        check({7'h00, rx_ready}, 8'h01, "ready after reset");
        check({7'h00, tx_out.valid}, 8'h00, "no reply after reset");
        make_cmd(16'h0001, 8'h00, 8'h00, 8'h03);
        repeat (5) cmd_q.push_front(8'h02 + 8'($random(seed) & 32'h7F));
        make_status(8'h00, 8'h00);
        run("noise then inquiry");
        acc.enc_write_pending = 1'b1;
        make_cmd(16'h0001, 8'h00, 8'h00, 8'h03);
        make_status(8'h80, 8'hC3);
        run("inquiry refused");
        foreach (acc_tab[k]) begin
            acc = bci_pkg::bci_acc_type'(acc_tab[k]);
            make_cmd(16'h0001, 8'h4D, 8'h00, 8'h03);
            make_status(8'hCD, status_tab[k]);
            run("config refused");
        end
        // Every acceptance check fails too, so only framing may be reported
        acc = bci_pkg::bci_acc_type'(4'h7);
        foreach (err_tab[k]) begin
            make_cmd(err_tab[k][55:40], err_tab[k][39:32],
                     err_tab[k][31:24], err_tab[k][23:16]);
            make_status(err_tab[k][15:8], err_tab[k][7:0]);
            run("framing error");
        end
        acc = '{1'b1, 1'b0, 1'b0, 1'b0};
        for (int k = 0; k < 4; k++) begin
            slow = k[0];
            arc_config = $random(seed);
            make_cmd(16'h0001, 8'h4D, 8'h00, 8'h03);
            make_arc(arc_config);
            run("config read");
        end
        make_cmd(16'h0001, 8'h4C, 8'h00, 8'h03);
        exp_q = {};
        run("unknown code");
        make_cmd(16'h0001, 8'h00, 8'h00, 8'h03);
        make_status(8'h00, 8'h00);
        run("final inquiry");
        tally_and_finish();
    end
endmodule
